/* core/lfwdt_pkg.sv */
// Constants, register map and timing figures of the low-frequency watchdog.
// Assumes a 50 MHz system clock and a 32.768 kHz low-frequency clock input.
//
// Operation
// R1 - Countdown advances on the 32.768 kHz clock
// R2 - Software keeps a low-frequency source enabled
// R3 - Initial count is start value times 256
// R4 - Count zero resets whole chip and peripherals
// R5 - Inactive after any reset until armed
// R6 - Armed only after both bytes written
// R7 - Two byte accesses, low byte first
// R8 - One pointer shared; other access restarts low
// R9 - Software pairs bytes without interleaving
// R10 - Reads return start value, not live count
// R11 - Every full write reloads and restarts counter; here expiry or retention power-down in the same cycle leaves it stopped
// R12 - Software rewrites before count reaches zero
// R13 - Start value zero gives 512 s timeout
// R14 - Timeout is value times 256 over 32768
// R15 - Only reset or retention power-down stops it
// R16 - Decrement by one per low-frequency cycle
package lfwdt_pkg;

    // Register bus geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    // Register offsets
    localparam logic [7:0] ADDR_START_VALUE = 8'haf;
    localparam logic [7:0] ADDR_STATUS      = 8'hf0;
    localparam logic [7:0] ADDR_COUNT_LO    = 8'hf1;
    localparam logic [7:0] ADDR_COUNT_MID   = 8'hf2;
    localparam logic [7:0] ADDR_COUNT_HI    = 8'hf3;

    // Reset values
    localparam logic [15:0] START_VALUE_RST = 16'h0000;
    localparam logic [7:0]  READ_IDLE       = 8'h00;

    // Status register field positions
    localparam int unsigned STAT_ACTIVE_BIT = 0;
    localparam int unsigned STAT_PTR_BIT    = 1;
    localparam int unsigned STAT_LASTWR_BIT = 2;

    // Counter layout: start value above an 8-bit zero offset
    localparam int unsigned START_W  = 16;
    localparam int unsigned OFFSET_W = 8;
    localparam int unsigned COUNT_W  = START_W + OFFSET_W;
    localparam logic [OFFSET_W-1:0] OFFSET_ZERO = 8'h00;
    localparam logic [COUNT_W-1:0]  COUNT_ONE   = 24'h000001;
    localparam logic [COUNT_W-1:0]  COUNT_ZERO  = 24'h000000;

    // Clock figures
    localparam int unsigned MCLK_HZ = 50_000_000;
    localparam int unsigned LF_HZ   = 32_768;

    // Length of the outgoing system reset pulse
    localparam int unsigned RST_PULSE_NS  = 1000;
    localparam int unsigned RST_PULSE_CYC =
        (RST_PULSE_NS * (MCLK_HZ / 1_000_000) + 999) / 1000;

endpackage : lfwdt_pkg

/* core/lfwdt_lf_tick.sv */
// Turns the free-running low-frequency clock into one system-clock pulse per rising edge.
// Assumes the low-frequency clock is much slower than the system clock.
`timescale 1ns/1ps

module lfwdt_lf_tick (
    input  wire logic i_mclk,
    input  wire logic i_rst,
    input  wire logic i_lfclk,
    output logic      o_tick
);

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
        logic tick;
    } lfwdt_tick_s;

    lfwdt_tick_s st_r;
    lfwdt_tick_s st_nxt;

    // Two-flop synchroniser, then a rising-edge detector on the second flop
    always_comb begin
        st_nxt       = st_r;
        st_nxt.sync1 = i_lfclk;
        st_nxt.sync2 = st_r.sync1;
        st_nxt.prev  = st_r.sync2;
        st_nxt.tick  = st_r.sync2 & ~st_r.prev;  // [R1]
    end

    // State register
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_tick = st_r.tick;

endmodule // lfwdt_lf_tick

/* core/lfwdt_core.sv */
// Low-frequency watchdog: byte-wide start-value register, countdown and system reset.
// Assumes a plain register port on i_mclk and a 32.768 kHz clock arriving as a pin.
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps

module lfwdt_core #(
    parameter int unsigned RST_PULSE_CYC = lfwdt_pkg::RST_PULSE_CYC
) (
    input  wire logic                        i_mclk,
    input  wire logic                        i_rst,
    input  wire logic                        i_lfclk,
    input  wire logic                        i_retention_pd,
    input  wire logic [lfwdt_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [lfwdt_pkg::DATA_W-1:0] i_wdata,
    input  wire logic                        i_wr,
    input  wire logic                        i_rd,
    output logic      [lfwdt_pkg::DATA_W-1:0] o_rdata,
    output logic                             o_active,
    output logic                             o_sys_rst
);

    localparam int unsigned RST_W = $clog2(RST_PULSE_CYC + 1);
    localparam logic [RST_W-1:0] RST_LEN  = RST_W'(RST_PULSE_CYC);
    localparam logic [RST_W-1:0] RST_NONE = '0;
    localparam logic [RST_W-1:0] RST_STEP = RST_W'(1);

    // Refuse a reset pulse that could not be seen
    generate
        if (RST_PULSE_CYC < 1) begin : g_bad_pulse
            $error("lfwdt_core: RST_PULSE_CYC must be at least 1");
        end
    endgenerate

    typedef struct packed {
        logic [lfwdt_pkg::START_W-1:0] start_value;
        logic [lfwdt_pkg::DATA_W-1:0]  low_pending;
        logic                          byte_ptr;
        logic                          last_wr;
        logic                          active;
        logic [lfwdt_pkg::COUNT_W-1:0] count;
        logic [lfwdt_pkg::DATA_W-1:0]  rdata;
        logic [RST_W-1:0]              rst_left;
        logic                          sys_rst;
    } lfwdt_core_s;

    lfwdt_core_s st_r;
    lfwdt_core_s st_nxt;

    logic lf_tick;
    logic hit_start;
    logic wr_ptr;
    logic rd_ptr;
    logic expire;

    // Low-frequency edge pulses, one per 32.768 kHz period
    lfwdt_lf_tick u_lf_tick (
        .i_mclk  (i_mclk),
        .i_rst   (i_rst),
        .i_lfclk (i_lfclk),
        .o_tick  (lf_tick)
    );

    // Address decode and effective byte pointer for each direction
    always_comb begin
        hit_start = (i_addr == lfwdt_pkg::ADDR_START_VALUE);
        wr_ptr    = st_r.last_wr ? st_r.byte_ptr : 1'b0;  // [R8]
        rd_ptr    = st_r.last_wr ? 1'b0 : st_r.byte_ptr;  // [R8]
        expire    = st_r.active && lf_tick && (st_r.count == lfwdt_pkg::COUNT_ONE);  // [R4]
    end

    // Next-state logic for registers, counter and reset pulse
    always_comb begin
        st_nxt       = st_r;
        st_nxt.rdata = lfwdt_pkg::READ_IDLE;

        // Countdown, one step per low-frequency period; zero start wraps to full range
        if (st_r.active && lf_tick) begin
            st_nxt.count = st_r.count - lfwdt_pkg::COUNT_ONE;  // [R16] [R13] [R14] [R1]
        end

        // Byte writes to the start value, low byte first
        if (i_wr && hit_start) begin
            st_nxt.last_wr = 1'b1;
            if (!wr_ptr) begin
                st_nxt.low_pending = i_wdata;  // [R7]
                st_nxt.byte_ptr    = 1'b1;
            end else begin
                st_nxt.start_value = {i_wdata, st_r.low_pending};  // [R7]
                st_nxt.count       = {i_wdata, st_r.low_pending,
                                      lfwdt_pkg::OFFSET_ZERO};  // [R3] [R11]
                st_nxt.active      = 1'b1;  // [R6]
                st_nxt.byte_ptr    = 1'b0;
            end
        end

        // Byte reads; the start-value address returns the programmed value
        if (i_rd) begin
            case (i_addr)
                lfwdt_pkg::ADDR_START_VALUE: begin
                    st_nxt.last_wr  = 1'b0;
                    st_nxt.byte_ptr = ~rd_ptr;  // [R8]
                    st_nxt.rdata    = rd_ptr ? st_r.start_value[15:8]
                                             : st_r.start_value[7:0];  // [R10] [R7]
                end
                lfwdt_pkg::ADDR_STATUS: begin
                    st_nxt.rdata = lfwdt_pkg::READ_IDLE;
                    st_nxt.rdata[lfwdt_pkg::STAT_ACTIVE_BIT] = st_r.active;
                    st_nxt.rdata[lfwdt_pkg::STAT_PTR_BIT]    = st_r.byte_ptr;
                    st_nxt.rdata[lfwdt_pkg::STAT_LASTWR_BIT] = st_r.last_wr;
                end
                lfwdt_pkg::ADDR_COUNT_LO:  st_nxt.rdata = st_r.count[7:0];
                lfwdt_pkg::ADDR_COUNT_MID: st_nxt.rdata = st_r.count[15:8];
                lfwdt_pkg::ADDR_COUNT_HI:  st_nxt.rdata = st_r.count[23:16];
                default:                   st_nxt.rdata = lfwdt_pkg::READ_IDLE;
            endcase
        end

        // Retention power-down stops the watchdog; software cannot
        if (i_retention_pd) begin
            st_nxt.active = 1'b0;  // [R15]
            st_nxt.count  = lfwdt_pkg::COUNT_ZERO;
        end

        // Expiry: fire the system reset and fall idle until rearmed
        if (expire) begin
            st_nxt.rst_left = RST_LEN;  // [R4]
            st_nxt.sys_rst  = 1'b1;
            st_nxt.active   = 1'b0;  // [R5]
        end else if (st_r.rst_left != RST_NONE) begin
            st_nxt.rst_left = st_r.rst_left - RST_STEP;
            st_nxt.sys_rst  = (st_r.rst_left != RST_STEP);
        end else begin
            st_nxt.sys_rst  = 1'b0;
        end
    end

    // State register; reset leaves the watchdog disarmed
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            st_r             <= '0;  // [R5] [R15]
            st_r.start_value <= lfwdt_pkg::START_VALUE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_rdata   = st_r.rdata;
    assign o_active  = st_r.active;
    assign o_sys_rst = st_r.sys_rst;  // [R4]

endmodule // lfwdt_core

/* sim/lfwdt_monitor.sv */
// Checker for the watchdog ports: read data, arming, disarming, reset pulse.
// Assumes one clock domain; bound to every lfwdt_core instance.
`timescale 1ns/1ps
module lfwdt_monitor #(
    parameter int unsigned RST_PULSE_CYC = 1
) (
    input wire logic                         i_mclk,
    input wire logic                         i_rst,
    input wire logic                         i_retention_pd,
    input wire logic [lfwdt_pkg::ADDR_W-1:0] i_addr,
    input wire logic                         i_wr,
    input wire logic                         i_rd,
    input wire logic [lfwdt_pkg::DATA_W-1:0] o_rdata,
    input wire logic                         o_active,
    input wire logic                         o_sys_rst
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    logic [7:0] hi_cnt_r;
    // Length of the current reset pulse
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) hi_cnt_r <= 8'h00;
        else hi_cnt_r <= o_sys_rst ? hi_cnt_r + 8'h01 : 8'h00;
    end
    sequence s_wr_sv;
        i_wr && i_addr == lfwdt_pkg::ADDR_START_VALUE;
    endsequence
    sequence s_pair;
        s_wr_sv ##1 s_wr_sv;
    endsequence
    property p_rd_idle; !i_rd |=> o_rdata == 8'h00; endproperty
    property p_arm; s_pair ##0 !i_retention_pd |=> o_active; endproperty
    property p_idle; !o_active && !i_wr |=> !o_active; endproperty
    property p_hold; o_active && !i_retention_pd |=> o_active || o_sys_rst; endproperty
    property p_expire; $rose(o_sys_rst) |-> !o_active && $past(o_active); endproperty
    property p_pulse; $fell(o_sys_rst) |-> 32'(hi_cnt_r) == RST_PULSE_CYC; endproperty
    property p_ret; i_retention_pd |=> !o_active; endproperty
    property p_reload; s_pair ##0 !o_sys_rst |=> !o_sys_rst [*8]; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    a_arm: assert property (p_arm) else $error("pair did not arm");
    a_idle: assert property (p_idle) else $error("armed without write");
    a_hold: assert property (p_hold) else $error("disarmed without cause");
    a_expire: assert property (p_expire) else $error("reset while idle");
    a_pulse: assert property (p_pulse) else $error("reset pulse length");
    a_ret: assert property (p_ret) else $error("retention did not stop");
    a_reload: assert property (p_reload) else $error("reset soon after load");
endmodule // lfwdt_monitor
bind lfwdt_core lfwdt_monitor #(.RST_PULSE_CYC(RST_PULSE_CYC)) lfwdt_monitor_inst (.*);

/* sim/tb_lfwdt_core.sv */
// Self-checking bench for the watchdog through its byte register port.
// Assumes a 50 MHz clock and a low-frequency clock of 10 system cycles.
`timescale 1ns/1ps
module tb_lfwdt_core;
    logic       i_mclk = 0, i_rst = 1, i_lfclk = 0, i_retention_pd = 0, i_wr = 0, i_rd = 0;
    logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata;
    logic       o_active, o_sys_rst;
    int         fails = 0, n_checks = 0, n;
    lfwdt_core #(.RST_PULSE_CYC(4)) lfwdt_core_inst (.*);
    // Clocks: system and free-running low-frequency
    initial forever #10 i_mclk = ~i_mclk;
    initial forever #100 i_lfclk = ~i_lfclk;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
        @(negedge i_mclk);
    endtask
    // Both start-value bytes on back-to-back cycles, strobe held high between them
    task automatic wr_pair(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= lo;
        @(posedge i_mclk);
        i_wdata <= hi;
        @(posedge i_mclk);
        i_wr <= 1'b0;
        @(negedge i_mclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        @(negedge i_mclk);
        chk(o_rdata, exp);
    endtask
    task automatic wait_rst(input int lim);
        n = 0;
        while (o_sys_rst !== 1'b1 && n < lim) begin
            @(negedge i_mclk);
            n++;
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Watchdog against a hung run
    initial begin
        #1_000_000;
        fails++;
        report_and_stop;
    end
    initial begin
        repeat (6) @(posedge i_mclk);
        i_rst <= 1'b0;
        rd(8'haf, 8'h00);
        rd(8'haf, 8'h00);
        rd(8'h10, 8'h00);
        chk({7'h0, o_active}, 8'h00);
        wr_pair(8'haf, 8'h34, 8'h12);
        chk({7'h0, o_active}, 8'h01);
        rd(8'hf0, 8'h05);
        rd(8'haf, 8'h34);
        rd(8'haf, 8'h12);
        wr(8'haf, 8'h56);
        rd(8'haf, 8'h34);
        wr(8'haf, 8'h78);
        wr(8'haf, 8'h9a);
        rd(8'haf, 8'h78);
        rd(8'haf, 8'h9a);
        rd(8'haf, 8'h78);
        $display("register access test done");
        wr_pair(8'haf, 8'h01, 8'h00);
        wait_rst(3000);
        chk({7'h0, n > 2540 && n < 2580}, 8'h01);
        chk({7'h0, o_active}, 8'h00);
        $display("expiry test done");
        repeat (3) begin
            wr_pair(8'haf, 8'h01, 8'h00);
            repeat (1500) @(posedge i_mclk);
        end
        chk({7'h0, o_sys_rst}, 8'h00);
        chk({7'h0, o_active}, 8'h01);
        i_retention_pd <= 1'b1;
        @(posedge i_mclk);
        i_retention_pd <= 1'b0;
        @(negedge i_mclk);
        chk({7'h0, o_active}, 8'h00);
        wr(8'hb0, 8'h01);
        wr(8'hb0, 8'h00);
        chk({7'h0, o_active}, 8'h00);
        rd(8'hf1, 8'h00);
        rd(8'hf3, 8'h00);
        $display("reload and stop test done");
        wr_pair(8'haf, 8'h00, 8'h00);
        chk({7'h0, o_active}, 8'h01);
        wait_rst(3000);
        chk({7'h0, o_sys_rst}, 8'h00);
        rd(8'hf3, 8'hff);
        $display("zero start value test done");
        // Second reset in mid-run must leave the watchdog disarmed and cleared
        @(posedge i_mclk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_mclk);
        i_rst <= 1'b0;
        chk({7'h0, o_active}, 8'h00);
        rd(8'haf, 8'h00);
        $display("reset test done");
        report_and_stop;
    end
endmodule // tb_lfwdt_core
